// File: dlip_pkg.sv
package dlip_pkg;

	// ------------------------------------------------------------
	// Register map (word offsets on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] DLIP_ADDR_CONTROL_FIRST  = 4'h0;
	localparam logic [3:0] DLIP_ADDR_CONTROL_SECOND = 4'h1;
	localparam logic [3:0] DLIP_ADDR_STATUS_FIRST   = 4'h2;
	localparam logic [3:0] DLIP_ADDR_STATUS_SECOND  = 4'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	// link_control_first
	localparam int DLIP_CF_ENABLE   = 0;
	localparam int DLIP_CF_IRQ_EN   = 1;
	localparam int DLIP_CF_SWAI     = 2;
	// link_control_second
	localparam int DLIP_CS_DIV_LSB  = 0;
	localparam int DLIP_CS_DIV_W    = 4;
	localparam int DLIP_CS_WIDE     = 4;
	localparam int DLIP_CS_TMO_LSB  = 8;
	localparam int DLIP_CS_TMO_W    = 8;
	// link_status_first
	localparam int DLIP_SF_TIMEOUT  = 0;
	localparam int DLIP_SF_PARITY   = 1;
	localparam int DLIP_SF_TERR     = 2;
	localparam int DLIP_SF_ERROR    = 7;
	// link_status_second
	localparam int DLIP_SS_IRQ_LVL  = 0;
	localparam int DLIP_SS_STOPPED  = 1;
	localparam int DLIP_SS_BUSY     = 2;

	// ------------------------------------------------------------
	// Reset values and divider count constants
	// ------------------------------------------------------------
	localparam logic [15:0] DLIP_CTRL_FIRST_RST  = 16'h0000;
	localparam logic [15:0] DLIP_CTRL_SECOND_RST = 16'h0000;
	localparam logic [3:0]  DLIP_DIV_ONE         = 4'h1;
	localparam logic [3:0]  DLIP_DIV_ZERO        = 4'h0;

	// Clock generator states
	typedef enum logic [1:0] {
		DLIP_CLK_IDLE  = 2'b00,
		DLIP_CLK_RUN   = 2'b01,
		DLIP_CLK_PARK  = 2'b10
	} dlip_clk_state_t;

endpackage

// File: dlip_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Two-stage synchroniser for one level
// ------------------------------------------------------------
module dlip_sync (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output var  logic sync_out
);

	logic meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// File: dlip_top.sv
// Notes on behaviour
// RULE_01 - Companion interrupt is active-high level request
// RULE_02 - Forward companion request only when enabled
// RULE_03 - Companion holds request until it is cleared
// RULE_04 - Status shows live companion interrupt level
// RULE_05 - Companion path keeps working in stop mode
// RULE_06 - Error sources level; write one clears all
// RULE_07 - Error interrupt has no local mask
// RULE_08 - Software configures width, divider, timeout first
// RULE_09 - Processor writes mode blocking before stop
// RULE_10 - Companion acknowledges mode write, sleeps after stop
// RULE_11 - Companion leaves regulator low power before request
// RULE_12 - Wake restarts clock; handler acknowledges source
// RULE_13 - Stop with wait-stop: finish high, park low
// RULE_14 - Error flag freezes buffers, substitutes idle
// RULE_15 - Error flag set with its cause flag
// RULE_16 - Pending transaction completes before clock stops
// RULE_17 - No interrupt unless interface enabled
// RULE_18 - Synchronise companion interrupt before use
`timescale 1ns/1ns
`default_nettype none

module dlip_top
	import dlip_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [15:0] reg_rdata,
	// Companion die interrupt pin
	input  wire logic        companion_irq_in,
	// Transaction engine events and state
	input  wire logic        txn_start,
	input  wire logic        txn_done,
	input  wire logic        evt_ack_timeout,
	input  wire logic        evt_parity_mismatch,
	input  wire logic        evt_target_error,
	input  wire logic [7:0]  txn_addr,
	input  wire logic [15:0] txn_data,
	// Processor stop request
	input  wire logic        stop_req,
	// Outputs
	output var  logic        companion_irq_signal,
	output var  logic        link_error_irq,
	output var  logic        link_clock_out,
	output var  logic        txn_idle_cmd,
	output var  logic [7:0]  addr_buf,
	output var  logic [15:0] data_buf
);

	// ------------------------------------------------------------
	// Registers and wires
	// ------------------------------------------------------------
	logic [15:0]     ctrl_first_reg;
	logic [15:0]     ctrl_second_reg;
	logic            err_reg;
	logic            tmo_reg;
	logic            par_reg;
	logic            terr_reg;
	logic            busy_reg;
	logic            stopped_reg;
	logic [3:0]      div_cnt_reg;
	dlip_clk_state_t clk_state_reg;
	dlip_clk_state_t clk_state_next;
	logic            irq_level;
	logic            stop_sync;

	wire wr_cf = reg_wr && (reg_addr == DLIP_ADDR_CONTROL_FIRST);
	wire wr_cs = reg_wr && (reg_addr == DLIP_ADDR_CONTROL_SECOND);
	wire wr_sf = reg_wr && (reg_addr == DLIP_ADDR_STATUS_FIRST);
	wire if_enabled = ctrl_first_reg[DLIP_CF_ENABLE];
	wire irq_enable = ctrl_first_reg[DLIP_CF_IRQ_EN];
	wire swai       = ctrl_first_reg[DLIP_CF_SWAI];
	wire [3:0] divider = ctrl_second_reg[DLIP_CS_DIV_LSB +: DLIP_CS_DIV_W];
	wire any_err   = evt_ack_timeout || evt_parity_mismatch || evt_target_error;
	wire err_clear = wr_sf && reg_wdata[DLIP_SF_ERROR];
	wire div_wrap  = (div_cnt_reg == DLIP_DIV_ZERO) || (div_cnt_reg >= divider);

	// ------------------------------------------------------------
	// Synchronisers for the companion pin and the stop request
	// ------------------------------------------------------------
	// Free-running on ref_clk, so usable during stop [RULE_05]
	dlip_sync u_sync_irq (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in (companion_irq_in),
		.sync_out (irq_level)            // [RULE_18]
	);

	dlip_sync u_sync_stop (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in (stop_req),
		.sync_out (stop_sync)
	);

	// ------------------------------------------------------------
	// Control registers; enable bit is set-only until reset
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_first_reg  <= DLIP_CTRL_FIRST_RST;
			ctrl_second_reg <= DLIP_CTRL_SECOND_RST;
		end else begin
			if (wr_cf) begin
				ctrl_first_reg <= reg_wdata | {15'h0000, if_enabled};
			end
			if (wr_cs) begin
				ctrl_second_reg <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Error flag and causes; new error wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			err_reg  <= 1'b0;
			tmo_reg  <= 1'b0;
			par_reg  <= 1'b0;
			terr_reg <= 1'b0;
		end else if (any_err && if_enabled) begin
			err_reg  <= 1'b1;                                   // [RULE_15]
			tmo_reg  <= evt_ack_timeout | (tmo_reg & ~err_clear);
			par_reg  <= evt_parity_mismatch | (par_reg & ~err_clear);
			terr_reg <= evt_target_error | (terr_reg & ~err_clear);
		end else if (err_clear) begin
			err_reg  <= 1'b0;                                   // [RULE_06]
			tmo_reg  <= 1'b0;
			par_reg  <= 1'b0;
			terr_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Buffers freeze while the error flag stands
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addr_buf     <= 8'h00;
			data_buf     <= 16'h0000;
			txn_idle_cmd <= 1'b0;
		end else begin
			txn_idle_cmd <= err_reg || (any_err && if_enabled);   // [RULE_14]
			if (txn_start && !err_reg) begin
				addr_buf <= txn_addr;                               // [RULE_14]
				data_buf <= txn_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			companion_irq_signal <= 1'b0;
			link_error_irq       <= 1'b0;
		end else begin
			// Level follows the pin; no latch here [RULE_01] [RULE_03]
			companion_irq_signal <= irq_level && irq_enable && if_enabled; // [RULE_02] [RULE_17]
			// Unmasked, enable only [RULE_07] [RULE_17]
			link_error_irq       <= err_reg && if_enabled;
		end
	end

	// ------------------------------------------------------------
	// Transaction tracking for stop entry
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
		end else if (txn_start && if_enabled && !err_reg) begin
			busy_reg <= 1'b1;
		end else if (txn_done || any_err) begin
			busy_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Link clock generator and stop parking
	// ------------------------------------------------------------
	always_comb begin
		clk_state_next = clk_state_reg;
		case (clk_state_reg)
			DLIP_CLK_IDLE: begin
				if (if_enabled && !stop_sync) begin
					clk_state_next = DLIP_CLK_RUN;
				end
			end
			DLIP_CLK_RUN: begin
				// Wait for pending work, then end the high phase [RULE_16] [RULE_13]
				if (stop_sync && swai && !busy_reg && !txn_start) begin
					clk_state_next = DLIP_CLK_PARK;
				end
			end
			DLIP_CLK_PARK: begin
				if (!stop_sync) begin
					clk_state_next = DLIP_CLK_RUN;   // Wake restarts clock [RULE_12]
				end
			end
			default: begin
				clk_state_next = DLIP_CLK_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_state_reg  <= DLIP_CLK_IDLE;
			div_cnt_reg    <= DLIP_DIV_ZERO;
			link_clock_out <= 1'b0;
			stopped_reg    <= 1'b0;
		end else begin
			clk_state_reg <= clk_state_next;
			stopped_reg   <= (clk_state_reg == DLIP_CLK_PARK) && !link_clock_out;
			if (clk_state_reg == DLIP_CLK_IDLE) begin
				div_cnt_reg    <= DLIP_DIV_ZERO;
				link_clock_out <= 1'b0;
			end else if (div_wrap) begin
				div_cnt_reg <= DLIP_DIV_ONE;
				// In park a high phase may still fall; never rises [RULE_13]
				if (clk_state_reg == DLIP_CLK_RUN) begin
					link_clock_out <= ~link_clock_out;
				end else begin
					link_clock_out <= 1'b0;
				end
			end else begin
				div_cnt_reg <= div_cnt_reg + DLIP_DIV_ONE;
			end
		end
	end

	// ------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ------------------------------------------------------------
	wire [15:0] sf_val = ({15'h0000, tmo_reg} << DLIP_SF_TIMEOUT)
	                   | ({15'h0000, par_reg} << DLIP_SF_PARITY)
	                   | ({15'h0000, terr_reg} << DLIP_SF_TERR)
	                   | ({15'h0000, err_reg} << DLIP_SF_ERROR);
	wire [15:0] ss_val = ({15'h0000, irq_level} << DLIP_SS_IRQ_LVL)  // [RULE_04]
	                   | ({15'h0000, stopped_reg} << DLIP_SS_STOPPED)
	                   | ({15'h0000, busy_reg} << DLIP_SS_BUSY);
	wire [15:0] rd_mux = (reg_addr == DLIP_ADDR_CONTROL_FIRST)  ? ctrl_first_reg  :
	                     (reg_addr == DLIP_ADDR_CONTROL_SECOND) ? ctrl_second_reg :
	                     (reg_addr == DLIP_ADDR_STATUS_FIRST)   ? sf_val          :
	                     (reg_addr == DLIP_ADDR_STATUS_SECOND)  ? ss_val          :
	                                                              16'h0000;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule

`default_nettype wire

// File: dlip_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dlip_top_sva
	import dlip_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        companion_irq_in,
	input wire logic        txn_start,
	input wire logic        txn_done,
	input wire logic        evt_ack_timeout,
	input wire logic        evt_parity_mismatch,
	input wire logic        evt_target_error,
	input wire logic        stop_req,
	input wire logic        companion_irq_signal,
	input wire logic        link_error_irq,
	input wire logic        link_clock_out,
	input wire logic        txn_idle_cmd,
	input wire logic [7:0]  addr_buf
);
	logic       en_reg;
	logic       ie_reg;
	logic       sw_reg;
	logic       busy_reg;
	logic [5:0] park_reg;
	// Decode of software writes, events and the quiet stop window
	wire ctl_wr  = reg_wr && reg_addr == DLIP_ADDR_CONTROL_FIRST;
	wire clr_wr  = reg_wr && reg_addr == DLIP_ADDR_STATUS_FIRST && reg_wdata[DLIP_SF_ERROR];
	wire evt_any = evt_ack_timeout | evt_parity_mismatch | evt_target_error;
	wire park_on = stop_req && sw_reg && !busy_reg;
	// Shadow of control bits, transaction busy and parked cycle count
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			{en_reg, ie_reg, sw_reg, busy_reg} <= 4'h0;
			park_reg <= 6'h00;
		end else begin
			en_reg   <= en_reg | (ctl_wr & reg_wdata[DLIP_CF_ENABLE]);
			ie_reg   <= ctl_wr ? reg_wdata[DLIP_CF_IRQ_EN] : ie_reg;
			sw_reg   <= ctl_wr ? reg_wdata[DLIP_CF_SWAI] : sw_reg;
			busy_reg <= txn_start | (busy_reg & ~txn_done);
			park_reg <= park_on ? park_reg + {5'h00, park_reg != 6'h3f} : 6'h00;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_err_cause: assert property ($rose(link_error_irq) |-> $past(evt_any, 2))
		else $error("error irq rose without a cause");
	a_err_set: assert property (evt_any && en_reg |-> ##2 link_error_irq)
		else $error("error irq missing after event");
	a_err_clear: assert property (clr_wr && !evt_any |-> ##2 !link_error_irq)
		else $error("error irq not cleared by write");
	a_err_hold: assert property ($fell(link_error_irq) |-> $past(clr_wr, 2))
		else $error("error irq dropped without clear");
	a_err_enable: assert property (link_error_irq |-> en_reg)
		else $error("error irq while disabled");
	a_comp_level: assert property (companion_irq_signal |-> $past(companion_irq_in, 3))
		else $error("companion irq without pin level");
	a_comp_mask: assert property (companion_irq_signal |-> $past(ie_reg) && $past(en_reg))
		else $error("companion irq while masked");
	// Two sync stages, one state step and at most one divider period to fall
	a_clk_parked: assert property (park_reg > 6'h18 |-> !link_clock_out)
		else $error("link clock not parked low");
	a_buf_frozen: assert property (link_error_irq |-> $stable(addr_buf) && txn_idle_cmd)
		else $error("buffer moved during error");
endmodule
bind dlip_top dlip_top_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .companion_irq_in(companion_irq_in),
	.txn_start(txn_start), .txn_done(txn_done), .evt_ack_timeout(evt_ack_timeout),
	.evt_parity_mismatch(evt_parity_mismatch), .evt_target_error(evt_target_error),
	.stop_req(stop_req), .companion_irq_signal(companion_irq_signal),
	.link_error_irq(link_error_irq), .link_clock_out(link_clock_out),
	.txn_idle_cmd(txn_idle_cmd), .addr_buf(addr_buf));
`default_nettype wire

// File: dlip_companion_model.sv
`timescale 1ns/1ns
`default_nettype none
module dlip_companion_model (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic wake,
	input  wire logic clear_ack,
	input  wire logic mode_req,
	input  wire logic cpu_stop,
	output var  logic companion_irq_in,
	output var  logic regulator_lp
);
	logic mode_reg;
	logic wake_reg;
	// Mode write, sleep after stop, wake order, request held until cleared
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			{companion_irq_in, regulator_lp, mode_reg, wake_reg} <= 4'h0;
		end else if (wake) begin
			regulator_lp <= 1'b0; // Regulator leaves low power first
			mode_reg     <= 1'b0;
			wake_reg     <= 1'b1;
		end else begin
			if (mode_req) mode_reg <= 1'b1; // Mode write acknowledged
			if (mode_reg && cpu_stop) regulator_lp <= 1'b1; // Sleep after stop
			if (wake_reg && !regulator_lp) companion_irq_in <= 1'b1;
			if (wake_reg && !regulator_lp) wake_reg <= 1'b0;
			if (clear_ack) companion_irq_in <= 1'b0; // Held until cleared
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import dlip_pkg::*;
;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, txn_start, txn_done, stop_req;
	logic        wake, clear_ack, mode_req, last_clk;
	logic        companion_irq_signal, link_error_irq, link_clock_out, txn_idle_cmd;
	logic [2:0]  evt_vec;
	logic [3:0]  reg_addr;
	logic [7:0]  txn_addr, addr_buf;
	logic [15:0] reg_wdata, reg_rdata, txn_data, data_buf;
	wire         companion_irq_in;
	int          fails, tests_run, edges, run;
	logic [2:0]  masks [4] = '{3'b001, 3'b010, 3'b100, 3'b111};
	dlip_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .companion_irq_in(companion_irq_in),
		.txn_start(txn_start), .txn_done(txn_done), .evt_ack_timeout(evt_vec[DLIP_SF_TIMEOUT]),
		.evt_parity_mismatch(evt_vec[DLIP_SF_PARITY]), .evt_target_error(evt_vec[DLIP_SF_TERR]),
		.txn_addr(txn_addr), .txn_data(txn_data), .stop_req(stop_req),
		.companion_irq_signal(companion_irq_signal), .link_error_irq(link_error_irq),
		.link_clock_out(link_clock_out), .txn_idle_cmd(txn_idle_cmd), .addr_buf(addr_buf),
		.data_buf(data_buf));
	dlip_companion_model u_comp (.ref_clk(ref_clk), .sys_rst(sys_rst), .wake(wake),
		.clear_ack(clear_ack), .mode_req(mode_req), .cpu_stop(stop_req),
		.companion_irq_in(companion_irq_in), .regulator_lp());
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task close_out();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		close_out();
	end
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk(name, exp, reg_rdata);
	endtask
	task pulse_evt(input logic [2:0] m);
		@(posedge ref_clk);
		evt_vec <= m;
		@(posedge ref_clk);
		evt_vec <= 3'b000;
	endtask
	task die(input logic w, input logic c, input logic m);
		@(posedge ref_clk);
		{wake, clear_ack, mode_req} <= {w, c, m};
		@(posedge ref_clk);
		{wake, clear_ack, mode_req} <= 3'b000;
	endtask
	task txn(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		{txn_start, txn_addr, txn_data} <= {1'b1, a, d};
		@(posedge ref_clk);
		{txn_start, txn_done} <= 2'b01;
		@(posedge ref_clk);
		txn_done <= 1'b0;
	endtask
	// Count link clock changes over n settled cycles
	task count_edges(input int n);
		#1;
		edges = 0;
		last_clk = link_clock_out;
		repeat (n) begin
			cyc(1);
			if (link_clock_out !== last_clk) edges++;
			last_clk = link_clock_out;
		end
	endtask
	initial begin
		{sys_rst, reg_wr, reg_rd, txn_start, txn_done, stop_req, wake, clear_ack, mode_req} = 9'h100;
		{evt_vec, reg_addr, reg_wdata, txn_addr, txn_data} = '0;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// Disabled interface keeps both requests quiet
		die(1'b1, 1'b0, 1'b0);
		pulse_evt(3'b001);
		cyc(5);
		chk("error irq", 16'h0000, {15'h0000, link_error_irq});
		chk("companion irq", 16'h0000, {15'h0000, companion_irq_signal});
		rd(DLIP_ADDR_STATUS_FIRST, 16'h0000, "status first");
		// Configure, enable, unmask and mask the companion request
		wr(DLIP_ADDR_CONTROL_SECOND, 16'h2002);
		wr(DLIP_ADDR_CONTROL_FIRST, 16'h0003);
		cyc(5);
		chk("companion irq", 16'h0001, {15'h0000, companion_irq_signal});
		rd(DLIP_ADDR_STATUS_SECOND, 16'h0001, "status second");
		wr(DLIP_ADDR_CONTROL_FIRST, 16'h0000);
		rd(DLIP_ADDR_CONTROL_FIRST, 16'h0001, "control first");
		rd(4'h9, 16'h0000, "unmapped");
		chk("companion irq", 16'h0000, {15'h0000, companion_irq_signal});
		wr(DLIP_ADDR_CONTROL_FIRST, 16'h0001);
		die(1'b0, 1'b1, 1'b0);
		cyc(4);
		rd(DLIP_ADDR_STATUS_SECOND, 16'h0000, "status second");
		// Errors freeze buffers, flag their cause and clear together
		txn(8'h5a, 16'h1234);
		cyc(2);
		for (int i = 0; i < 4; i++) begin
			pulse_evt(masks[i]);
			cyc(3);
			chk("error irq", 16'h0001, {15'h0000, link_error_irq});
			rd(DLIP_ADDR_STATUS_FIRST, 16'h0080 | 16'(masks[i]), "status first");
			txn(8'ha5, 16'hbeef);
			cyc(2);
			chk("addr buf", 16'h005a, {8'h00, addr_buf});
			chk("data buf", 16'h1234, data_buf);
			chk("idle cmd", 16'h0001, {15'h0000, txn_idle_cmd});
			wr(DLIP_ADDR_STATUS_FIRST, 16'h0080);
			cyc(3);
			chk("error irq", 16'h0000, {15'h0000, link_error_irq});
			rd(DLIP_ADDR_STATUS_FIRST, 16'h0000, "status first");
		end
		// Stop parks the clock after a pending transfer, companion wakes
		wr(DLIP_ADDR_CONTROL_FIRST, 16'h0007);
		count_edges(40);
		chk("clock edges", 16'h0014, 16'(edges));
		die(1'b0, 1'b0, 1'b1);
		@(posedge ref_clk);
		txn_start <= 1'b1;
		@(posedge ref_clk);
		{txn_start, stop_req} <= 2'b01;
		count_edges(20);
		chk("clock edges", 16'h000a, 16'(edges));
		@(posedge ref_clk);
		txn_done <= 1'b1;
		@(posedge ref_clk);
		txn_done <= 1'b0;
		run = 0;
		for (int n = 0; n < 100 && run < 20; n++) begin
			cyc(1);
			run = (link_clock_out === 1'b0) ? run + 1 : 0;
		end
		if (run < 20) begin
			fails++;
			close_out();
		end
		rd(DLIP_ADDR_STATUS_SECOND, 16'h0002, "status second");
		die(1'b1, 1'b0, 1'b0);
		cyc(12);
		chk("companion irq", 16'h0001, {15'h0000, companion_irq_signal});
		@(posedge ref_clk);
		stop_req <= 1'b0;
		count_edges(40);
		chk("clock restart", 16'h0001, {15'h0000, edges > 0});
		die(1'b0, 1'b1, 1'b0);
		cyc(5);
		chk("companion irq", 16'h0000, {15'h0000, companion_irq_signal});
		close_out();
	end
endmodule
`default_nettype wire
